/* File: arx_params.svh */
// Constants for the asynchronous receive clock and data recovery block
`ifndef ARX_PARAMS_SVH
`define ARX_PARAMS_SVH
`define ARX_SPB_NORMAL   5'h10
`define ARX_SPB_DOUBLE   5'h08
`define ARX_VOTE_N_FIRST 5'h08
`define ARX_VOTE_D_FIRST 5'h04
`define ARX_BITS_MIN     4'h5
`define ARX_BITS_MAX     4'ha
`define ARX_DIV_RESET    12'h000
`endif

/* File: arx_pkg.sv */
// Types shared by the receive recovery block
package arx_pkg;
  typedef enum logic [2:0] {
    ARX_IDLE  = 3'b001,
    ARX_START = 3'b010,
    ARX_DATA  = 3'b100
  } arx_state_e;

  typedef struct packed {
    logic [9:0] data;
    logic       stop_err;
  } arx_frame_s;

  typedef struct packed {
    logic meta;
    logic sync;
  } arx_sync_s;
endpackage

/* File: arx_sync.sv */
// Two-flop synchroniser for the serial line
`timescale 1ns/10ps
module arx_sync
  import arx_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  arx_sync_s s_q;
  arx_sync_s s_d;

  // Next state: meta feeds only sync
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // Line idles high, so reset to one
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule

/* File: arx_rx.sv */
// Receive clock and data recovery with start qualification and voting
`timescale 1ns/10ps
`include "arx_params.svh"
module arx_rx
  import arx_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        serial_rx_line,
  input  wire logic        receiver_enable_bit,
  input  wire logic        double_speed_select,
  input  wire logic [11:0] baud_divisor,
  input  wire logic [3:0]  frame_bits,
  output logic             line_override,
  output logic [9:0]       rx_data,
  output logic             stop_bit_error_flag,
  output logic             rx_done
);
  typedef struct packed {
    arx_state_e  st;
    logic [11:0] div;
    logic [4:0]  smp;
    logic [3:0]  bitn;
    logic [1:0]  votes;
    logic        prev;
    logic [9:0]  shreg;
    logic        ovr;
    arx_frame_s  out;
    logic        done;
  } arx_state_s;

  arx_state_s r_q;
  arx_state_s r_d;
  logic       rx_s;
  logic       tick;
  logic [4:0] spb;
  logic [4:0] vfirst;
  logic [3:0] nbits;
  logic       vote_now;

  // Synchronise the line before anything looks at it
  arx_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (serial_rx_line),
    .dout    (rx_s)
  );

  // Majority of three: two votes from earlier samples plus current
  function automatic logic maj3(input logic [1:0] v, input logic c);
    maj3 = ((v + {1'b0, c}) >= 2'h2);
  endfunction

  // Sample tick from the divisor; the receiver's own rate error is only the divisor's rounding
  assign tick   = (r_q.div == 12'h000);
  assign spb    = double_speed_select ? `ARX_SPB_DOUBLE : `ARX_SPB_NORMAL;
  assign vfirst = double_speed_select ? `ARX_VOTE_D_FIRST : `ARX_VOTE_N_FIRST;
  // Out-of-range sizes are clamped so a frame always ends
  assign nbits  = (frame_bits < `ARX_BITS_MIN) ? `ARX_BITS_MIN :
                  (frame_bits > `ARX_BITS_MAX) ? `ARX_BITS_MAX : frame_bits;

  // Recovery state machine; sample counter runs on baud ticks
  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    r_d.ovr  = receiver_enable_bit;
    if (!receiver_enable_bit) begin
      r_d.st  = ARX_IDLE;
      r_d.div = `ARX_DIV_RESET;
      // Treat the line as idle high, so the first low sample after enable can start a frame
      r_d.prev = 1'b1;
    end else begin
      r_d.div = tick ? baud_divisor : r_q.div - 12'h001;
      if (tick) begin
        r_d.prev = rx_s;
        case (r_q.st)
          ARX_IDLE: begin
            if (r_q.prev && !rx_s) begin
              r_d.st    = ARX_START;
              r_d.smp   = 5'h01;
              r_d.votes = 2'h0;
            end
          end
          ARX_START: begin
            r_d.smp = r_q.smp + 5'h01;
            if (r_d.smp >= vfirst && r_d.smp <= vfirst + 5'h02) begin
              if (r_d.smp == vfirst + 5'h02) begin
                if (maj3(r_q.votes, rx_s)) begin
                  r_d.st   = ARX_IDLE;
                  r_d.prev = 1'b1;
                end else begin
                  r_d.st    = ARX_DATA;
                  // Counter runs on from the centre sample, so bit 0 starts at its own sample 1
                  r_d.bitn  = 4'h0;
                  r_d.votes = 2'h0;
                end
              end else begin
                r_d.votes = r_q.votes + {1'b0, rx_s};
              end
            end
          end
          ARX_DATA: begin
            // Sample number wraps per bit; state number equals sample index
            r_d.smp = (r_q.smp + 5'h01 > spb) ? 5'h01 : r_q.smp + 5'h01;
            if (r_d.smp >= vfirst && r_d.smp < vfirst + 5'h02) begin
              r_d.votes = r_q.votes + {1'b0, rx_s};
            end else if (r_d.smp == vfirst + 5'h02) begin
              r_d.votes = 2'h0;
              if (r_q.bitn == nbits) begin
                // Only the first stop bit is voted; any later stop bits pass as idle line
                r_d.out.stop_err = !maj3(r_q.votes, rx_s);
                r_d.out.data     = r_q.shreg >> (4'ha - nbits);
                r_d.done         = 1'b1;
                r_d.st           = double_speed_select ? ARX_DATA : ARX_IDLE;
                // Edge detector keeps this sample, so a low stop bit cannot fake a start
                r_d.bitn         = double_speed_select ? r_q.bitn + 4'h1 : 4'h0;
              end else begin
                r_d.shreg = {maj3(r_q.votes, rx_s), r_q.shreg[9:1]};
                r_d.bitn  = r_q.bitn + 4'h1;
              end
            end else if (r_q.bitn > nbits && r_d.smp == vfirst + 5'h03) begin
              // Double speed holds off one more sample slot after stop votes
              r_d.st   = ARX_IDLE;
              r_d.bitn = 4'h0;
            end
          end
          default: r_d.st = ARX_IDLE;
        endcase
      end
    end
  end

  // Single state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '{st: ARX_IDLE, prev: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign line_override       = r_q.ovr;
  assign rx_data             = r_q.out.data;
  assign stop_bit_error_flag = r_q.out.stop_err;
  assign rx_done             = r_q.done;

  // Vote on the present sample, shared by the checks below
  assign vote_now = maj3(r_q.votes, rx_s);

  // Start rejected when qualifying majority is high
  noise_reject_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (r_q.st == ARX_START && tick && r_q.smp == vfirst + 5'h01 && maj3(r_q.votes, rx_s)
      && receiver_enable_bit) |=> r_q.st == ARX_IDLE)
    else $error("noise start not rejected");
  enable_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !receiver_enable_bit |=> (r_q.st == ARX_IDLE && !rx_done))
    else $error("disable did not stop reception");
  idle_edge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (r_q.st == ARX_IDLE && tick && r_q.prev && !rx_s && receiver_enable_bit)
      |=> (r_q.st == ARX_START && r_q.smp == 5'h01))
    else $error("start qualification not begun");
  sample_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    r_q.st == ARX_DATA |-> r_q.smp <= `ARX_SPB_NORMAL)
    else $error("sample state out of range");
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_done |=> !rx_done)
    else $error("done longer than one cycle");
  stop_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (r_q.st == ARX_DATA && tick && r_q.bitn == nbits && r_d.smp == vfirst + 5'h02
      && receiver_enable_bit) |=> (rx_done && stop_bit_error_flag == !$past(vote_now)))
    else $error("stop bit flag mismatch");
  normal_rearm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rx_done && !double_speed_select && !$past(double_speed_select)) |-> r_q.st == ARX_IDLE)
    else $error("normal mode not rearmed");
  double_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rx_done && double_speed_select && $past(double_speed_select)) |-> r_q.st == ARX_DATA)
    else $error("double speed rearmed early");
  override_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    receiver_enable_bit |=> line_override)
    else $error("override not following enable");
  // Valid start keeps the counter on its centre sample so bit slots stay aligned
  start_align_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (r_q.st == ARX_START && tick && r_q.smp == vfirst + 5'h01 && !vote_now && receiver_enable_bit)
      |=> (r_q.st == ARX_DATA && r_q.smp == $past(vfirst) + 5'h02 && r_q.bitn == 4'h0))
    else $error("start not aligned to data recovery");
  // The line reaches the sampler exactly two clocks late, through both flops
  sync_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_s == $past(serial_rx_line, 2))
    else $error("synchroniser delay wrong");
  // Each tick reloads the divisor, so one sample spans baud_divisor+1 clocks
  tick_reload_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tick && receiver_enable_bit) |=> r_q.div == $past(baud_divisor))
    else $error("sample tick period wrong");
  // Short characters come out right-aligned with the unused top bits zero
  data_align_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_done |-> (rx_data >> nbits) == 10'h000)
    else $error("unused data bits not zero");
  // Main scenarios: good frame, bad stop, double speed, noise, abort
  frame_ok_c: cover property (@(posedge ref_clk) disable iff (sys_rst) rx_done && !stop_bit_error_flag);
  frame_err_c: cover property (@(posedge ref_clk) disable iff (sys_rst) rx_done && stop_bit_error_flag);
  double_c: cover property (@(posedge ref_clk) disable iff (sys_rst) rx_done && double_speed_select);
  noise_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    r_q.st == ARX_START && tick && r_q.smp == vfirst + 5'h01 && vote_now);
  abort_c: cover property (@(posedge ref_clk) disable iff (sys_rst) !receiver_enable_bit && r_q.st != ARX_IDLE);
endmodule

/* File: arx_tx_model.sv */
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/10ps
module arx_tx_model (
  input  wire logic ref_clk,
  output logic      line
);
  // Line idles high between frames, like a released line with a pull-up
  initial line = 1'b1;

  // Holds a level for n system clocks; entered and left at a falling edge
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n) @(negedge ref_clk);
  endtask

  // Whole frame at exactly the receiver rate, so no rate error is spent here
  task automatic send(input logic [9:0] d, input int nb, input logic stop, input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) hold(d[i], bc);
    hold(stop, bc);
    hold(1'b1, bc);
  endtask

  // Short low spike that must not pass start qualification
  task automatic glitch();
    hold(1'b0, 3);
    hold(1'b1, 200);
  endtask
endmodule

/* File: arx_rx_tb_top.sv */
// Self-checking bench for the receive recovery block
`timescale 1ns/10ps
module arx_rx_tb_top
  import arx_pkg::*;
;
  `define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end
  logic        ref_clk             = 1'b0;
  logic        sys_rst             = 1'b1;
  logic        serial_rx_line;
  logic        receiver_enable_bit = 1'b1;
  logic        double_speed_select = 1'b0;
  logic [11:0] baud_divisor        = 12'h001;
  logic [3:0]  frame_bits          = 4'h8;
  logic        line_override;
  logic [9:0]  rx_data;
  logic        stop_bit_error_flag;
  logic        rx_done;
  int          bad_count           = 0;
  int          compares            = 0;
  logic [31:0] seed                = 32'h2c3d;
  arx_frame_s  exp_q[$];
  arx_frame_s  e;

  // Free-running system clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  arx_tx_model far (.ref_clk(ref_clk), .line(serial_rx_line));

  arx_rx dut (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .serial_rx_line      (serial_rx_line),
    .receiver_enable_bit (receiver_enable_bit),
    .double_speed_select (double_speed_select),
    .baud_divisor        (baud_divisor),
    .frame_bits          (frame_bits),
    .line_override       (line_override),
    .rx_data             (rx_data),
    .stop_bit_error_flag (stop_bit_error_flag),
    .rx_done             (rx_done)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Each completed frame is matched with the oldest expected one
  always @(negedge ref_clk) begin
    if (rx_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(rx_done, 1'b0, "unexpected frame")
      end else begin
        e = exp_q.pop_front();
        `CHK(rx_data, e.data, "data")
        `CHK(stop_bit_error_flag, e.stop_err, "stop flag")
      end
    end
  end

  // Random data and divisor; divisor only changes while the line is idle
  task automatic frame(input int nb, input logic stop);
    logic [9:0] d;
    int         bc;
    seed = lfsr(seed);
    d = seed[9:0];
    baud_divisor = 12'(seed[11:10]) + 12'h001;
    bc = (int'(baud_divisor) + 1) * (double_speed_select ? 8 : 16);
    frame_bits = 4'(nb);
    exp_q.push_back('{data: d & ((10'h001 << nb) - 10'h001), stop_err: ~stop});
    far.send(d, nb, stop, bc);
  endtask

  task automatic report_and_stop();
    `CHK(exp_q.size(), 0, "frames missing")
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: both speeds, every size, a bad stop, noise, then an abort
  initial begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int m = 0; m < 2; m++) begin
      double_speed_select = m[0];
      for (int nb = 5; nb <= 10; nb++) frame(nb, 1'b1);
      frame(8, 1'b0);
      frame(7, 1'b1);
      far.glitch();
    end
    fork
      frame(10, 1'b1);
      begin
        repeat (60) @(negedge ref_clk);
        receiver_enable_bit = 1'b0;
        void'(exp_q.pop_back());
        @(negedge ref_clk);
        `CHK(line_override, 1'b0, "override kept")
      end
    join
    receiver_enable_bit = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(line_override, 1'b1, "override missing")
    frame(6, 1'b1);
    repeat (50) @(negedge ref_clk);
    report_and_stop();
  end

  // Longest run is near 11,500 clocks; the watchdog allows about twice that
  initial begin
    #200000;
    bad_count++;
    $display("mismatch at %0t: timeout", $time);
    report_and_stop();
  end
endmodule
